// [hdl/ppk_pkg.sv]
// Constants, field layouts and carrier types of the process data packer.
// Assumes a single 100 MHz clock and a word-wide register port.
package ppk_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------------
  localparam logic [7:0] PPK_OFF_CMD = 8'h00;  // Command register.
  localparam logic [7:0] PPK_OFF_FEED = 8'h04; // Descriptor byte feed.
  localparam logic [7:0] PPK_OFF_STAT = 8'h08; // Packer status.
  localparam logic [7:0] PPK_OFF_CS = 8'h0C;   // Channel control/status.
  localparam logic [7:0] PPK_OFF_IF0 = 8'h10;  // Interface word 0.
  localparam logic [7:0] PPK_OFF_IF1 = 8'h14;  // Interface word 1.
  localparam logic [7:0] PPK_OFF_IF2 = 8'h18;  // Interface word 2.
  localparam logic [7:0] PPK_OFF_SEL = 8'h1C;  // Element select.
  localparam logic [7:0] PPK_OFF_VAL = 8'h20;  // Selected element value.

  // ----------------------------------------------------------------------
  // Record, element, direction and mode codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] PPK_REC_PD = 8'hA0;
  localparam logic [7:0] PPK_REC_MODE = 8'hB0;
  localparam logic [7:0] PPK_ET_PAD = 8'h00;
  localparam logic [7:0] PPK_ET_SIGNED = 8'h03;
  localparam logic [7:0] PPK_ET_NV_SIGNED = 8'h05;
  localparam logic [7:0] PPK_ET_BOOL = 8'h07;
  localparam logic [7:0] PPK_DIR_CODE_IN = 8'h00;
  localparam logic [7:0] PPK_DIR_CODE_BI = 8'h40;
  localparam logic [7:0] PPK_DIR_CODE_OUT = 8'h80;
  localparam logic [7:0] PPK_HARDWARE_MODE_KIND = 8'h00;
  localparam logic [7:0] PPK_SOFTWARE_MODE_KIND = 8'h01;
  // Internal direction encoding kept in the element table.
  localparam logic [1:0] PPK_DIR_IN = 2'h0;
  localparam logic [1:0] PPK_DIR_BI = 2'h1;
  localparam logic [1:0] PPK_DIR_OUT = 2'h2;

  // ----------------------------------------------------------------------
  // Command bits, field positions and sizes
  // ----------------------------------------------------------------------
  localparam int PPK_CMD_XFER_BIT = 12;
  localparam logic [15:0] PPK_CMD_STOP_ALL = 16'h0800;
  localparam logic [15:0] PPK_CMD_RST = 16'h0000;
  localparam int PPK_ST_REC_ERR = 8;
  localparam int PPK_ST_DIR_ERR = 9;
  localparam int PPK_ST_SIZE_ERR = 10;
  localparam int PPK_ST_TIMEOUT = 11;
  localparam int PPK_ST_BUSY = 12;
  localparam int PPK_ST_SW_MODE = 16;
  localparam int PPK_ST_HW_MODE = 24;
  localparam int PPK_IF_BITS = 96;
  localparam logic [8:0] PPK_IF_BITS_9 = 9'h060;
  localparam int PPK_MAX_ELEMS = 16;
  // Two 32-bit limits and a 16-bit location follow the direction byte.
  localparam logic [3:0] PPK_SKIP_BYTES = 4'hA;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int PPK_CLK_MHZ = 100;
  localparam int PPK_XFER_TIMEOUT_US = 100;
  localparam int PPK_XFER_TIMEOUT_CYC = PPK_XFER_TIMEOUT_US * PPK_CLK_MHZ;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ppk_bus_t;

  typedef struct packed {
    logic [7:0] remote_flt;
    logic [7:0] link_state_code;
    logic [7:0] status;
    logic [7:0] local_flt;
  } ppk_cs_t;

  typedef struct packed {
    logic [7:0] size;
    logic [7:0] etype;
    logic [1:0] dir;
    logic [6:0] offset;
  } ppk_elem_t;

endpackage

// [hdl/ppk_sync.sv]
// Two-stage synchroniser for pins that come from the remote link.
// Assumes the far side holds data steady while its flag is up.
`timescale 1ns/100ps
module ppk_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Asynchronous input and its synchronised copy.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // First stage, read by the second stage only.
  logic [W-1:0] meta_r;

  // ----------------------------------------------------------------------
  // Synchroniser flops
  // ----------------------------------------------------------------------
  // Both stages clear to zero so nothing downstream sees an unknown.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule // ppk_sync

// [hdl/ppk_elem_mem.sv]
// Small table of parsed element descriptors, one entry per element.
// Assumes one writer and one reader on the same clock.
`timescale 1ns/100ps
module ppk_elem_mem import ppk_pkg::*; #(
  parameter int DEPTH = PPK_MAX_ELEMS,
  parameter int AW = 4
) (
  // Clock.
  input wire logic clk,
  // Write port.
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input ppk_elem_t wdata,
  // Read port; data comes out of a register.
  input wire logic [AW-1:0] raddr,
  output ppk_elem_t rdata
);

  // Descriptor storage; no reset, the count of valid entries guards it.
  ppk_elem_t mem [DEPTH];

  // ----------------------------------------------------------------------
  // Access
  // ----------------------------------------------------------------------
  // Registered read keeps the output free of array decode glitches.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule // ppk_elem_mem

// [hdl/ppk_packer.sv]
// Process data descriptor parser and element packer for one link channel.
// Assumes a register master on clk and a remote partner on async pins.
`timescale 1ns/100ps
module ppk_packer import ppk_pkg::*; #(
  parameter int TIMEOUT_CYCLES = PPK_XFER_TIMEOUT_CYC,
  parameter int MAX_ELEMS = PPK_MAX_ELEMS
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Register port.
  input ppk_bus_t bus,
  output logic [31:0] rdata,
  // Link side, handshake and process words.
  output logic xfer_req,
  output logic [95:0] outgoing_process_bytes,
  input wire logic xfer_ack,
  input wire logic [95:0] incoming_process_bytes,
  input ppk_cs_t link_status_in
);

  // ----------------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------------
  // Descriptor parser position within the current record.
  typedef enum logic [3:0] {
    P_TYPE, P_SIZE, P_ETYPE, P_DIR, P_SKIP, P_UNIT, P_NAME,
    M_INDEX, M_KIND, M_UNUSED, M_NAME
  } ppk_pstate_t;

  // Transfer handshake with the remote side.
  typedef enum logic [1:0] {X_IDLE, X_REQ, X_DROP} ppk_xstate_t;

  typedef struct packed {
    ppk_pstate_t pstate;
    ppk_xstate_t xstate;
    logic [15:0] cmd;
    logic [3:0] skip;
    ppk_elem_t cur;
    logic [4:0] elem_cnt;
    logic [7:0] bit_total;
    logic [95:0] out_word;
    logic [95:0] in_word;
    logic [95:0] out_mask;
    logic [95:0] in_mask;
    logic rec_err;
    logic dir_err;
    logic size_err;
    logic timeout;
    logic [7:0] mode_idx;
    logic [7:0] mode_kind;
    logic [7:0] hw_mode_idx;
    logic [7:0] sw_mode_idx;
    logic [3:0] sel;
    ppk_cs_t cs;
    logic [95:0] link_tx;
    logic req;
    logic [15:0] tmo_cnt;
    logic [31:0] rdata;
  } ppk_state_t;

  ppk_state_t state_r; // Registered state.
  ppk_state_t state_nxt; // Next state.
  logic ack_s; // Synchronised acknowledge.
  logic [95:0] ipb_s; // Synchronised incoming words.
  ppk_cs_t cs_s; // Synchronised channel status.
  logic mem_we; // Commit a parsed element.
  ppk_elem_t mem_rd; // Element under the select register.

  // Bits [off, off+size) of the interface words, used for masks and values.
  function automatic logic [95:0] range_mask(input logic [6:0] off,
                                            input logic [7:0] size);
    logic [95:0] m;
    m = '0;
    for (int i = 0; i < PPK_IF_BITS; i++) begin
      m[i] = (i >= int'(off)) && (i < int'(off) + int'(size));
    end
    return m;
  endfunction

  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  // Every link pin passes two flops before the logic sees it.
  ppk_sync #(.W(129)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d({xfer_ack, incoming_process_bytes, link_status_in}),
    .q({ack_s, ipb_s, cs_s})
  );

  // Element table, read address follows the select register's next value.
  ppk_elem_mem #(.DEPTH(MAX_ELEMS), .AW(4)) u_mem (
    .clk(clk),
    .we(mem_we),
    .waddr(state_r.elem_cnt[3:0]),
    // The next value carries the offset and direction of this very byte.
    .wdata(state_nxt.cur),
    .raddr(state_nxt.sel),
    .rdata(mem_rd)
  );

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Stop-all clears come before parser sets, but the handshake's command clear overrides a same-cycle command write.
  always_comb begin
    logic feed;
    logic [7:0] b;
    logic [8:0] sum;
    logic [95:0] m;
    logic [95:0] src;
    logic [95:0] v;
    logic [31:0] val;
    feed = bus.wr && (bus.addr == PPK_OFF_FEED);
    b = bus.wdata[7:0];
    sum = {1'b0, state_r.bit_total} + {1'b0, state_r.cur.size};
    m = range_mask(state_r.bit_total[6:0], state_r.cur.size);
    src = '0;
    v = '0;
    val = '0;
    mem_we = 1'b0;
    state_nxt = state_r;
    state_nxt.rdata = '0;

    // Register writes; the control/status word ignores writes.
    if (bus.wr) begin
      unique case (bus.addr)
        PPK_OFF_CMD: begin
          state_nxt.cmd = bus.wdata[15:0];
        end
        PPK_OFF_IF0: state_nxt.out_word[31:0] = bus.wdata;
        PPK_OFF_IF1: state_nxt.out_word[63:32] = bus.wdata;
        PPK_OFF_IF2: state_nxt.out_word[95:64] = bus.wdata;
        PPK_OFF_SEL: state_nxt.sel = bus.wdata[3:0];
        default: begin
        end
      endcase
    end

    // Stop-all forgets the layout so a new mode can be discovered.
    if (bus.wr && bus.addr == PPK_OFF_CMD &&
        bus.wdata[15:0] == PPK_CMD_STOP_ALL) begin
      state_nxt.elem_cnt = '0;
      state_nxt.bit_total = '0;
      state_nxt.out_mask = '0;
      state_nxt.in_mask = '0;
      state_nxt.rec_err = 1'b0;
      state_nxt.dir_err = 1'b0;
      state_nxt.size_err = 1'b0;
      state_nxt.timeout = 1'b0;
      state_nxt.pstate = P_TYPE;
    end

    // Descriptor byte stream parser.
    if (feed) begin
      unique case (state_r.pstate)
        P_TYPE: begin
          if (b == PPK_REC_PD) begin
            state_nxt.pstate = P_SIZE;
          end else if (b == PPK_REC_MODE) begin
            state_nxt.pstate = M_INDEX;
          end else begin
            state_nxt.rec_err = 1'b1;
          end
        end
        P_SIZE: begin
          state_nxt.cur.size = b;
          state_nxt.pstate = P_ETYPE;
        end
        P_ETYPE: begin
          state_nxt.cur.etype = b;
          state_nxt.pstate = P_DIR;
        end
        P_DIR: begin
          state_nxt.skip = PPK_SKIP_BYTES - 4'h1;
          state_nxt.pstate = P_SKIP;
          state_nxt.cur.offset = state_r.bit_total[6:0];
          state_nxt.cur.dir = (b == PPK_DIR_CODE_BI) ? PPK_DIR_BI :
                              (b == PPK_DIR_CODE_OUT) ? PPK_DIR_OUT :
                              PPK_DIR_IN;
          if (b != PPK_DIR_CODE_IN && b != PPK_DIR_CODE_BI &&
              b != PPK_DIR_CODE_OUT) begin
            state_nxt.dir_err = 1'b1;
          end else if (state_r.cur.size == 8'h00 ||
                       sum > PPK_IF_BITS_9 ||
                       int'(state_r.elem_cnt) >= MAX_ELEMS) begin
            state_nxt.size_err = 1'b1;
          end else begin
            // Fill continues from the last element's top bit.
            mem_we = 1'b1;
            state_nxt.bit_total = sum[7:0];
            state_nxt.elem_cnt = state_r.elem_cnt + 5'h01;
            // Pad occupies width but is neither sent nor returned.
            if (state_r.cur.etype != PPK_ET_PAD) begin
              if (b != PPK_DIR_CODE_IN) begin
                state_nxt.out_mask = state_r.out_mask | m;
              end
              if (b != PPK_DIR_CODE_OUT) begin
                state_nxt.in_mask = state_r.in_mask | m;
              end
            end
          end
        end
        P_SKIP: begin
          // Limits and location are presentation data only.
          state_nxt.skip = state_r.skip - 4'h1;
          if (state_r.skip == 4'h0) begin
            state_nxt.pstate = P_UNIT;
          end
        end
        P_UNIT: begin
          if (b == 8'h00) begin
            state_nxt.pstate = P_NAME;
          end
        end
        P_NAME: begin
          if (b == 8'h00) begin
            state_nxt.pstate = P_TYPE;
          end
        end
        M_INDEX: begin
          state_nxt.mode_idx = b;
          state_nxt.pstate = M_KIND;
        end
        M_KIND: begin
          state_nxt.mode_kind = b;
          state_nxt.pstate = M_UNUSED;
        end
        M_UNUSED: begin
          state_nxt.pstate = M_NAME;
          if (state_r.mode_kind == PPK_HARDWARE_MODE_KIND) begin
            state_nxt.hw_mode_idx = state_r.mode_idx;
          end else if (state_r.mode_kind == PPK_SOFTWARE_MODE_KIND) begin
            state_nxt.sw_mode_idx = state_r.mode_idx;
          end else begin
            state_nxt.rec_err = 1'b1;
          end
        end
        M_NAME: begin
          if (b == 8'h00) begin
            state_nxt.pstate = P_TYPE;
          end
        end
        default: begin
          state_nxt.pstate = P_TYPE;
        end
      endcase
    end

    // Transfer handshake; only channel 0 exists, other mask bits ignored.
    unique case (state_r.xstate)
      X_IDLE: begin
        if (state_r.cmd[PPK_CMD_XFER_BIT] && state_r.cmd[0]) begin
          state_nxt.link_tx = state_r.out_word & state_r.out_mask;
          state_nxt.req = 1'b1;
          state_nxt.tmo_cnt = '0;
          state_nxt.xstate = X_REQ;
        end else if (state_r.cmd != PPK_CMD_RST) begin
          // Commands with nothing to exchange finish at once.
          state_nxt.cmd = PPK_CMD_RST;
        end
      end
      X_REQ: begin
        state_nxt.tmo_cnt = state_r.tmo_cnt + 16'h0001;
        if (ack_s) begin
          // Input bits are replaced, all others keep their last value.
          state_nxt.in_word = (state_r.in_word & ~state_r.in_mask) |
                              (ipb_s & state_r.in_mask);
          state_nxt.cs = cs_s;
          state_nxt.req = 1'b0;
          state_nxt.xstate = X_DROP;
        end else if (int'(state_r.tmo_cnt) >= TIMEOUT_CYCLES - 1) begin
          state_nxt.timeout = 1'b1;
          // Hold the count so it never passes the limit while idle.
          state_nxt.tmo_cnt = state_r.tmo_cnt;
          state_nxt.req = 1'b0;
          state_nxt.cmd = PPK_CMD_RST;
          state_nxt.xstate = X_IDLE;
        end
      end
      X_DROP: begin
        // Command clears only once the partner has let go of ack.
        if (!ack_s) begin
          state_nxt.cmd = PPK_CMD_RST;
          state_nxt.xstate = X_IDLE;
        end
      end
      default: begin
        state_nxt.xstate = X_IDLE;
      end
    endcase

    // Selected element value, shifted down and sign or truth adjusted.
    src = (mem_rd.dir == PPK_DIR_OUT) ? state_r.out_word : state_r.in_word;
    m = range_mask(7'h00, mem_rd.size);
    v = (src >> mem_rd.offset) & m;
    val = v[31:0];
    if (mem_rd.etype == PPK_ET_BOOL) begin
      val = {31'h0, |v};
    end else if ((mem_rd.etype == PPK_ET_SIGNED ||
                  mem_rd.etype == PPK_ET_NV_SIGNED) &&
                 mem_rd.size != 8'h00 &&
                 v[7'(mem_rd.size - 8'h01)]) begin
      val = v[31:0] | ~m[31:0];
    end
    if ({1'b0, state_r.sel} >= state_r.elem_cnt) begin
      val = '0;
    end

    // Read data for the cycle after the strobe; unmapped reads give zero.
    if (bus.rd) begin
      unique case (bus.addr)
        PPK_OFF_CMD: state_nxt.rdata = {16'h0, state_r.cmd};
        PPK_OFF_STAT: begin
          state_nxt.rdata[4:0] = state_r.elem_cnt;
          state_nxt.rdata[PPK_ST_REC_ERR] = state_r.rec_err;
          state_nxt.rdata[PPK_ST_DIR_ERR] = state_r.dir_err;
          state_nxt.rdata[PPK_ST_SIZE_ERR] = state_r.size_err;
          state_nxt.rdata[PPK_ST_TIMEOUT] = state_r.timeout;
          state_nxt.rdata[PPK_ST_BUSY] = state_r.cmd != PPK_CMD_RST;
          state_nxt.rdata[PPK_ST_SW_MODE +: 8] = state_r.sw_mode_idx;
          state_nxt.rdata[PPK_ST_HW_MODE +: 8] = state_r.hw_mode_idx;
        end
        PPK_OFF_CS: state_nxt.rdata = state_r.cs;
        PPK_OFF_IF0: state_nxt.rdata = state_r.in_word[31:0];
        PPK_OFF_IF1: state_nxt.rdata = state_r.in_word[63:32];
        PPK_OFF_IF2: state_nxt.rdata = state_r.in_word[95:64];
        PPK_OFF_SEL: state_nxt.rdata = {28'h0, state_r.sel};
        PPK_OFF_VAL: state_nxt.rdata = val;
        default: state_nxt.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Every field resets to a constant; the table contents need no reset.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= '0;
      state_r.pstate <= P_TYPE;
      state_r.xstate <= X_IDLE;
      state_r.cmd <= PPK_CMD_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rdata = state_r.rdata;
  assign xfer_req = state_r.req;
  assign outgoing_process_bytes = state_r.link_tx;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic feed_a;
  assign feed_a = bus.wr && bus.addr == PPK_OFF_FEED;

  property p_pd_type;
    feed_a && state_r.pstate == P_TYPE && bus.wdata[7:0] == PPK_REC_PD
      |=> state_r.pstate == P_SIZE;
  endproperty
  a_pd_type: assert property (p_pd_type)
    else $error("process record type not accepted");

  property p_bad_type;
    feed_a && state_r.pstate == P_TYPE && bus.wdata[7:0] != PPK_REC_PD &&
      bus.wdata[7:0] != PPK_REC_MODE
      |=> state_r.rec_err && state_r.pstate == P_TYPE;
  endproperty
  a_bad_type: assert property (p_bad_type)
    else $error("unknown record type not flagged");

  property p_bad_dir;
    feed_a && state_r.pstate == P_DIR && bus.wdata[7:0] == 8'h20
      |=> state_r.dir_err && $stable(state_r.elem_cnt);
  endproperty
  a_bad_dir: assert property (p_bad_dir)
    else $error("invalid direction accepted");

  property p_fill;
    mem_we |=> state_r.bit_total == $past(state_r.bit_total) +
                $past(state_r.cur.size);
  endproperty
  a_fill: assert property (p_fill)
    else $error("bit position did not advance by element size");

  property p_limit;
    state_r.bit_total <= PPK_IF_BITS_9[7:0];
  endproperty
  a_limit: assert property (p_limit)
    else $error("packed elements exceed interface words");

  property p_tx;
    $rose(state_r.req) |-> state_r.link_tx ==
      ($past(state_r.out_word) & $past(state_r.out_mask));
  endproperty
  a_tx: assert property (p_tx)
    else $error("outgoing word not masked copy of host data");

  property p_done;
    state_r.xstate == X_DROP && !ack_s |=> state_r.cmd == PPK_CMD_RST;
  endproperty
  a_done: assert property (p_done)
    else $error("command not cleared after transfer");

  property p_cs_ro;
    bus.wr && bus.addr == PPK_OFF_CS && state_r.xstate == X_IDLE
      |=> $stable(state_r.cs);
  endproperty
  a_cs_ro: assert property (p_cs_ro)
    else $error("status word changed by host write");

  property p_sw_mode;
    feed_a && state_r.pstate == M_UNUSED &&
      state_r.mode_kind == PPK_SOFTWARE_MODE_KIND
      |=> state_r.sw_mode_idx == $past(state_r.mode_idx);
  endproperty
  a_sw_mode: assert property (p_sw_mode)
    else $error("software mode index not stored");

  property p_tmo;
    int'(state_r.tmo_cnt) < TIMEOUT_CYCLES;
  endproperty
  a_tmo: assert property (p_tmo)
    else $error("transfer outlived its timeout");

  c_xfer: cover property ($rose(state_r.req) ##[1:50] !state_r.req);
  c_commit: cover property (mem_we);
  c_mode: cover property (feed_a && state_r.pstate == M_UNUSED);

endmodule // ppk_packer

// [tb/ppk_remote.sv]
// Behavioural remote card that answers the packer's transfer handshake.
// Assumes four-phase req/ack, all on the packer clock.
`timescale 1ns/100ps
module ppk_remote import ppk_pkg::*; #(
  parameter logic [95:0] PAT = '0,
  parameter logic [31:0] ST = '0
) (
  // Clock, reset and a switch that silences the card.
  input wire logic clk,
  input wire logic resetn,
  input wire logic mute,
  // Handshake and process data.
  input wire logic xfer_req,
  output logic xfer_ack,
  output logic [95:0] incoming_process_bytes,
  output ppk_cs_t link_status_in
);
  logic [1:0] cnt_r; // Answer delay count.
  // Answers on the third cycle; released data is inverted, never held.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {cnt_r, xfer_ack} <= '0;
      incoming_process_bytes <= ~PAT;
      link_status_in <= ~ST;
    end else if (xfer_req && !xfer_ack && !mute) begin
      cnt_r <= cnt_r + 2'h1;
      if (cnt_r == 2'h2) begin
        xfer_ack <= 1'b1;
        incoming_process_bytes <= PAT;
        link_status_in <= ST;
      end
    end else if (!xfer_req && xfer_ack) begin
      {cnt_r, xfer_ack} <= '0;
      incoming_process_bytes <= ~PAT;
      link_status_in <= ~ST;
    end
  end
endmodule // ppk_remote

// [tb/ppk_packer_tb.sv]
// Self-checking bench of the packer against the remote card model.
// Assumes the packer's one-cycle register port and a 100 MHz clock.
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %h", $time, a); end end
module ppk_packer_tb import ppk_pkg::*;;
  localparam logic [95:0] PAT = 96'h0123_4567_89AB_CDEF_5555_5C55;
  localparam logic [31:0] ST = 32'h8142_0310;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic mute = 1'b0;
  ppk_bus_t bus = '0;
  logic [31:0] rdata, v;
  logic xfer_req, xfer_ack;
  logic [95:0] obytes, ibytes;
  ppk_cs_t lstat;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  // Short timeout keeps the silent-card case quick.
  ppk_packer #(.TIMEOUT_CYCLES(40)) dut (.clk(clk), .resetn(resetn),
    .bus(bus), .rdata(rdata), .xfer_req(xfer_req),
    .outgoing_process_bytes(obytes), .xfer_ack(xfer_ack),
    .incoming_process_bytes(ibytes), .link_status_in(lstat));
  ppk_remote #(.PAT(PAT), .ST(ST)) remote (.clk(clk), .resetn(resetn),
    .mute(mute), .xfer_req(xfer_req), .xfer_ack(xfer_ack),
    .incoming_process_bytes(ibytes), .link_status_in(lstat));
  always #5 clk = ~clk;
  // A hang counts as a mismatch.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      report_and_stop;
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask
  // Read data stands only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 d = rdata;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    rd(a, v);
    `CHK(v, e)
  endtask
  // Feeds four header bytes, first byte first, then z zero bytes.
  task automatic feed(input logic [31:0] h, input int z);
    for (int i = 3; i >= 0; i--) wr(PPK_OFF_FEED, {24'h0, h[8*i +: 8]});
    repeat (z) wr(PPK_OFF_FEED, 32'h0);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 100; i++) begin
      rd(PPK_OFF_CMD, v);
      if (v === 32'h0) break;
    end
    `CHK(v, 32'h0)
  endtask
  task automatic report_and_stop;
    if (n_fail == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Main sequence: setup, descriptors, one transfer, one timeout.
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    wr(PPK_OFF_CMD, {16'h0, PPK_CMD_STOP_ALL});
    wait_idle;
    wr(PPK_OFF_CMD, 32'h0901);
    wait_idle;
    feed(32'hA008_0280, 12);
    feed(32'hA004_0300, 12);
    feed(32'hA008_0220, 12);
    feed(32'hB002_0100, 1);
    feed(32'hB005_0000, 1);
    wr(PPK_OFF_FEED, 32'h55);
    chk_rd(PPK_OFF_STAT, 32'h0502_0302);
    wr(PPK_OFF_IF0, 32'hFFFF_FFA5);
    wr(PPK_OFF_CMD, 32'h1001);
    wait_idle;
    `CHK(obytes, 96'hA5)
    rd(PPK_OFF_IF0, v);
    `CHK(v & 32'hF00, 32'hC00)
    chk_rd(PPK_OFF_CS, ST);
    wr(PPK_OFF_CS, 32'h0);
    chk_rd(PPK_OFF_CS, ST);
    wr(PPK_OFF_SEL, 32'h1);
    chk_rd(PPK_OFF_VAL, 32'hFFFF_FFFC);
    wr(PPK_OFF_SEL, 32'h0);
    chk_rd(PPK_OFF_VAL, 32'hA5);
    mute <= 1'b1;
    wr(PPK_OFF_CMD, 32'h1001);
    wait_idle;
    `CHK(xfer_req, 1'b0)
    rd(PPK_OFF_IF0, v);
    `CHK(v & 32'hF00, 32'hC00)
    chk_rd(PPK_OFF_STAT, 32'h0502_0B02);
    report_and_stop;
  end
endmodule // ppk_packer_tb
